// ---- pkg/sdpc_pkg.sv ----
// Constants and types for the frame reference divider and pulser control block
// Operation
// RQ1: Six-bit request delay in whole steps
// RQ2: Software picks delay from captured position
// RQ3: Request clear empties latch, resets sync
// RQ4: Clear held forces request low, except repeater
// RQ5: Software pulses clear before sync or capture
// RQ6: Pulse count n gives n pulses
// RQ7: Pulser counter gates divider output
// RQ8: Twelve-bit divider, ratio 2 to 4095
// RQ9: Software keeps divider frequencies in limits
// RQ10: Odd ratios only with delay bypass; reset loads ratio 5 with bypass bit 10 clear
// RQ11: Inphase strength resets to maximum
// RQ12: Two-bit phase selects interpolator clock
// RQ13: Mode field picks continuous, pulser, repeater
// RQ14: Continuous mode emits free divider clock
// RQ15: Pulser emits programmed pulses per request
// RQ16: Repeater gives one pulse per request
// RQ17: Pin function bit selects sync or request
// RQ18: Latch holds request high until cleared
// RQ19: Counter reloads per request, stops when done
package sdpc_pkg;
   localparam logic [7:0] SDPC_ADDR_REQ = 8'h0F;
   localparam logic [7:0] SDPC_ADDR_DIV = 8'h10;
   localparam logic [7:0] SDPC_ADDR_MODE = 8'h11;
   localparam logic [15:0] SDPC_RST_REQ = 16'h0181;
   localparam logic [15:0] SDPC_RST_DIV = 16'h1005;
   localparam logic [15:0] SDPC_RST_MODE = 16'h07F0;
   localparam int SDPC_CLR_BIT = 0;
   localparam int SDPC_DLY_LSB = 1;
   localparam int SDPC_LATCH_BIT = 7;
   localparam int SDPC_PINFN_BIT = 8;
   localparam int SDPC_FORCE_BIT = 9;
   localparam int SDPC_BYP_BIT = 10;
   localparam int SDPC_DIV_LSB = 0;
   localparam int SDPC_CNT_LSB = 12;
   localparam int SDPC_MODE_LSB = 0;
   localparam int SDPC_PHASE_LSB = 2;
   localparam int SDPC_STR_LSB = 4;
   localparam int SDPC_DLY_DEPTH = 64;
   typedef enum logic [1:0] {
      SDPC_MODE_CONT = 2'b00,
      SDPC_MODE_PULSER = 2'b01,
      SDPC_MODE_REPEAT = 2'b10,
      SDPC_MODE_RSVD = 2'b11
   } sdpc_mode_t;
endpackage : sdpc_pkg

// ---- hdl/sdpc_delay_line.sv ----
// Request delay line: a tapped shift register of whole clock steps
`timescale 1ns/10ps
`default_nettype none
module sdpc_delay_line (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Data
   input wire logic din_in,
   input wire logic [5:0] tap_in,
   output logic dout_out
);
   logic [sdpc_pkg::SDPC_DLY_DEPTH-1:0] line_q;
   logic [sdpc_pkg::SDPC_DLY_DEPTH-1:0] line_d;
   logic dout_q;
   logic dout_d;

   always_comb begin
      line_d = {line_q[sdpc_pkg::SDPC_DLY_DEPTH-2:0], din_in};
      // Tap 0 still costs the output register cycle
      dout_d = (tap_in == 6'h00) ? din_in : line_q[tap_in - 6'h01]; // RQ1
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         line_q <= '0;
         dout_q <= 1'b0;
      end else begin
         line_q <= line_d;
         dout_q <= dout_d;
      end
   end

   assign dout_out = dout_q;
endmodule : sdpc_delay_line
`default_nettype wire

// ---- hdl/sdpc_top.sv ----
// Frame reference divider, pulser and request control
`timescale 1ns/10ps
`default_nettype none
module sdpc_top (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   // Request pin
   input wire logic sysref_request_input_in,
   // Outputs
   output logic frame_ref_output_0_out,
   output logic sync_pulse_out,
   output logic [1:0] out0_interp_phase_out,
   output logic [6:0] out0_inphase_strength_out,
   output logic delay_generator_bypass_out
);
   // Register state
   logic [15:0] req_reg_q, req_reg_d;
   logic [15:0] div_reg_q, div_reg_d;
   logic [15:0] mode_reg_q, mode_reg_d;
   logic [15:0] rdata_q, rdata_d;
   // Field views
   logic request_clear;
   logic [5:0] request_delay_steps;
   logic request_latch_enable;
   logic request_pin_function;
   logic request_force;
   logic [11:0] frame_ref_divider;
   logic [3:0] pulser_count;
   sdpc_pkg::sdpc_mode_t generation_mode;

   assign request_clear = req_reg_q[sdpc_pkg::SDPC_CLR_BIT];
   assign request_delay_steps = req_reg_q[sdpc_pkg::SDPC_DLY_LSB +: 6];
   assign request_latch_enable = req_reg_q[sdpc_pkg::SDPC_LATCH_BIT];
   assign request_pin_function = req_reg_q[sdpc_pkg::SDPC_PINFN_BIT];
   assign request_force = req_reg_q[sdpc_pkg::SDPC_FORCE_BIT];
   assign frame_ref_divider = div_reg_q[sdpc_pkg::SDPC_DIV_LSB +: 12];
   assign pulser_count = div_reg_q[sdpc_pkg::SDPC_CNT_LSB +: 4];
   assign generation_mode = sdpc_pkg::sdpc_mode_t'(mode_reg_q[sdpc_pkg::SDPC_MODE_LSB +: 2]);

   // Pin synchroniser, then delay line
   logic req_s1_q, req_s2_q;
   logic req_dly;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
      end else begin
         req_s1_q <= sysref_request_input_in;
         req_s2_q <= req_s1_q;
      end
   end

   sdpc_delay_line u_delay (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .din_in(req_s2_q),
      .tap_in(request_delay_steps),
      .dout_out(req_dly)
   );

   // Register writes; reserved upper bits of the mode word read zero
   always_comb begin
      req_reg_d = req_reg_q;
      div_reg_d = div_reg_q;
      mode_reg_d = mode_reg_q;
      rdata_d = 16'h0000;
      if (reg_wr_in) begin
         case (reg_addr_in)
            sdpc_pkg::SDPC_ADDR_REQ: req_reg_d = {5'h00, reg_wdata_in[10:0]}; // RQ3
            sdpc_pkg::SDPC_ADDR_DIV: div_reg_d = reg_wdata_in;
            sdpc_pkg::SDPC_ADDR_MODE: mode_reg_d = {5'h00, reg_wdata_in[10:0]};
            default: req_reg_d = req_reg_q;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            sdpc_pkg::SDPC_ADDR_REQ: rdata_d = req_reg_q;
            sdpc_pkg::SDPC_ADDR_DIV: rdata_d = div_reg_q;
            sdpc_pkg::SDPC_ADDR_MODE: rdata_d = mode_reg_q;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         req_reg_q <= sdpc_pkg::SDPC_RST_REQ; // RQ3
         div_reg_q <= sdpc_pkg::SDPC_RST_DIV; // RQ6 RQ8
         mode_reg_q <= sdpc_pkg::SDPC_RST_MODE; // RQ11
         rdata_q <= 16'h0000;
      end else begin
         req_reg_q <= req_reg_d;
         div_reg_q <= div_reg_d;
         mode_reg_q <= mode_reg_d;
         rdata_q <= rdata_d;
      end
   end

   // Request latch, edge detect and internal request
   logic latch_q, latch_d;
   logic req_prev_q, req_prev_d;
   logic req_int;
   logic req_rise;

   always_comb begin
      latch_d = latch_q;
      if (request_clear) begin
         latch_d = 1'b0; // RQ3
      end else if (request_latch_enable && req_dly && !req_prev_q) begin
         latch_d = 1'b1; // RQ18
      end
      // Clear holds the request low except in repeater mode
      if (request_clear && generation_mode != sdpc_pkg::SDPC_MODE_REPEAT) begin
         req_int = 1'b0; // RQ4
      end else begin
         req_int = req_dly | latch_q | request_force;
      end
      req_prev_d = req_int;
      req_rise = req_int && !req_prev_q;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         latch_q <= 1'b0;
         req_prev_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         req_prev_q <= req_prev_d;
      end
   end

   // Divider; clear or a sync request restarts its timing
   logic [11:0] div_cnt_q, div_cnt_d;
   logic div_out_q, div_out_d;
   logic div_wrap;
   logic sync_hit;
   logic [11:0] half;

   always_comb begin
      sync_hit = req_rise && !request_pin_function; // RQ17
      half = {1'b0, frame_ref_divider[11:1]};
      // Reserved ratios 0 and 1 hold the count at zero and the output high
      div_wrap = (div_cnt_q >= frame_ref_divider - 12'h001) || (frame_ref_divider < 12'h002); // RQ8
      div_cnt_d = div_wrap ? 12'h000 : div_cnt_q + 12'h001;
      if (request_clear || sync_hit) begin
         div_cnt_d = 12'h000; // RQ3
      end
      // High for the first half; odd ratios give a duty below one half
      div_out_d = (div_cnt_d < half) || (frame_ref_divider < 12'h002);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_cnt_q <= 12'h000;
         div_out_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         div_out_q <= div_out_d;
      end
   end

   // Pulser gate counter
   logic [3:0] pulses_q, pulses_d;
   logic div_fall;
   logic div_prev_q;
   logic out_q, out_d;
   logic sync_q, sync_d;
   logic pulser_req;

   always_comb begin
      div_fall = div_prev_q && !div_out_q;
      pulser_req = req_rise && request_pin_function;
      pulses_d = pulses_q;
      if (generation_mode == sdpc_pkg::SDPC_MODE_PULSER && pulser_req) begin
         // Reserved zero still gives one pulse
         pulses_d = (pulser_count == 4'h0) ? 4'h1 : pulser_count; // RQ6 RQ19
      end else if (div_fall && pulses_q != 4'h0) begin
         pulses_d = pulses_q - 4'h1; // RQ19
      end
      case (generation_mode)
         sdpc_pkg::SDPC_MODE_CONT: out_d = div_out_q; // RQ14
         sdpc_pkg::SDPC_MODE_PULSER: out_d = div_out_q && (pulses_q != 4'h0) && !div_fall; // RQ7 RQ15
         sdpc_pkg::SDPC_MODE_REPEAT: out_d = req_dly; // RQ16
         default: out_d = 1'b0; // RQ13
      endcase
      sync_d = sync_hit;
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pulses_q <= 4'h0;
         div_prev_q <= 1'b0;
         out_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         pulses_q <= pulses_d;
         div_prev_q <= div_out_q;
         out_q <= out_d;
         sync_q <= sync_d;
      end
   end

   // Delay generator settings, registered straight out
   logic [1:0] phase_q;
   logic [6:0] str_q;
   logic byp_q;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_q <= sdpc_pkg::SDPC_RST_MODE[sdpc_pkg::SDPC_PHASE_LSB +: 2];
         str_q <= sdpc_pkg::SDPC_RST_MODE[sdpc_pkg::SDPC_STR_LSB +: 7];
         byp_q <= sdpc_pkg::SDPC_RST_REQ[sdpc_pkg::SDPC_BYP_BIT];
      end else begin
         phase_q <= mode_reg_q[sdpc_pkg::SDPC_PHASE_LSB +: 2]; // RQ12
         str_q <= mode_reg_q[sdpc_pkg::SDPC_STR_LSB +: 7];
         byp_q <= req_reg_q[sdpc_pkg::SDPC_BYP_BIT];
      end
   end

   assign reg_rdata_out = rdata_q;
   assign frame_ref_output_0_out = out_q;
   assign sync_pulse_out = sync_q;
   assign out0_interp_phase_out = phase_q;
   assign out0_inphase_strength_out = str_q;
   assign delay_generator_bypass_out = byp_q;

   // Checks
   chk_clear_forces_low: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ4
      (request_clear && generation_mode != sdpc_pkg::SDPC_MODE_REPEAT) |-> !req_int)
      else $error("request not held low under clear");
   chk_latch_cleared: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ3
      request_clear |=> !latch_q)
      else $error("latch survived clear");
   chk_latch_holds: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ18
      (latch_q && !request_clear) |=> latch_q)
      else $error("latch dropped without clear");
   chk_pulser_reload: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ19
      (generation_mode == sdpc_pkg::SDPC_MODE_PULSER && pulser_req && pulser_count != 4'h0)
      |=> pulses_q == $past(pulser_count))
      else $error("pulse counter not reloaded");
   chk_pulser_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ7
      (generation_mode == sdpc_pkg::SDPC_MODE_PULSER && pulses_q == 4'h0 && !pulser_req)
      |=> !out_q)
      else $error("pulser output while count spent");
   chk_repeat_follow: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ16
      (generation_mode == sdpc_pkg::SDPC_MODE_REPEAT) ##1 (generation_mode == sdpc_pkg::SDPC_MODE_REPEAT)
      |-> out_q == $past(req_dly))
      else $error("repeater output differs from request");
   chk_cont_follow: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ14
      (generation_mode == sdpc_pkg::SDPC_MODE_CONT) |=> out_q == $past(div_out_q))
      else $error("continuous output differs from divider");
   chk_div_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ8
      (frame_ref_divider >= 12'h002) |-> div_cnt_q < frame_ref_divider || $changed(frame_ref_divider))
      else $error("divider count out of range");
   chk_rsvd_mode: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ13
      (generation_mode == sdpc_pkg::SDPC_MODE_RSVD) |=> !out_q)
      else $error("reserved mode drives output");
   chk_sync_pin: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ17
      sync_q |-> !$past(request_pin_function))
      else $error("sync pulse in request function");
endmodule : sdpc_top
`default_nettype wire

// ---- verif/sdpc_req_source.sv ----
// Request source model driving the request pin
`timescale 1ns/10ps
`default_nettype none
module sdpc_req_source (
   // Clock
   input wire logic core_clk_in,
   // Request pin
   output logic req_out
);
   initial req_out = 1'b0;
   // Source always drives the pin, so idle low is a real level
   task automatic send(input int hi_cycles);
      @(posedge core_clk_in);
      req_out <= 1'b1;
      repeat (hi_cycles) @(posedge core_clk_in);
      req_out <= 1'b0;
   endtask : send
endmodule : sdpc_req_source
`default_nettype wire

// ---- verif/test_sdpc_top.sv ----
// Testbench for the frame reference divider and pulser control block
`timescale 1ns/10ps
`default_nettype none
module test_sdpc_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic prev = 1'b0;
   logic [15:0] rdata;
   logic req;
   logic out0;
   logic sync;
   logic [1:0] phase;
   logic [6:0] strength;
   logic bypass;
   logic [15:0] exp_q[$];
   logic [6:0] st;
   int bad_count = 0;
   int checks_done = 0;
   int edges = 0;
   int syncs = 0;
   int lat0;
   int lat1;
   int cnt[3] = '{1, 3, 15};
   sdpc_top i_sdpc_top (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sysref_request_input_in(req),
      .frame_ref_output_0_out(out0), .sync_pulse_out(sync), .out0_interp_phase_out(phase),
      .out0_inphase_strength_out(strength), .delay_generator_bypass_out(bypass));
   sdpc_req_source i_sdpc_req_source (.core_clk_in(clk), .req_out(req));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic results;
      $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg
   // Edges counted between falling edges, away from the race at the rising one
   task automatic window(input int cyc);
      @(negedge clk);
      edges = 0;
      repeat (cyc) @(negedge clk);
   endtask : window
   task automatic lat(output int n);
      n = 0;
      fork
         i_sdpc_req_source.send(3);
         while (sync !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
         end
      join
      repeat (5) @(posedge clk);
      if (n >= 200) begin
         bad_count++;
         $display("CHECK FAILED sync wait expected pulse seen none");
         results();
      end
   endtask : lat
   // Read data are taken only in the cycle after the strobe
   always @(posedge clk) begin
      rd_seen <= rd;
      prev <= out0;
      if (out0 === 1'b1 && prev === 1'b0) edges++;
      if (sync === 1'b1) syncs++;
      if (rd_seen) cmp("read data", exp_q.pop_front(), rdata);
   end
   initial begin
      void'($urandom(32'h52FF));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      cmp("strength", 16'h007F, {9'h000, strength});
      rd_reg(8'h0F, 16'h0181);
      rd_reg(8'h10, 16'h1005);
      rd_reg(8'h11, 16'h07F0);
      rd_reg(8'h20, 16'h0000);
      for (int p = 0; p < 4; p++) begin
         st = 7'($urandom_range(127, 0));
         wr_reg(8'h11, {5'h1F, st, p[1:0], 2'b00});
         rd_reg(8'h11, {5'h00, st, p[1:0], 2'b00});
         cmp("phase", 16'(p), {14'h0000, phase});
         cmp("strength", {9'h000, st}, {9'h000, strength});
      end
      wr_reg(8'h0F, 16'h0500);
      rd_reg(8'h0F, 16'h0500);
      cmp("bypass", 16'h0001, {15'h0000, bypass});
      // Even ratios only, as delay generators may be in use
      for (int i = 1; i <= 3; i++) begin
         wr_reg(8'h10, 16'h1000 | 16'(2 * i));
         // Let the old ratio drain so the window sees whole periods
         repeat (8) @(posedge clk);
         window(480);
         cmp("continuous edges", 16'(240 / i), 16'(edges));
      end
      wr_reg(8'h11, 16'h07F1);
      foreach (cnt[i]) begin
         wr_reg(8'h10, {4'(cnt[i]), 12'h004});
         fork
            i_sdpc_req_source.send(2);
            window(150);
         join
         cmp("pulser edges", 16'(cnt[i]), 16'(edges));
      end
      wr_reg(8'h0F, 16'h0101);
      fork
         i_sdpc_req_source.send(2);
         window(100);
      join
      cmp("cleared pulser edges", 16'h0000, 16'(edges));
      wr_reg(8'h11, 16'h07F2);
      fork
         begin
            i_sdpc_req_source.send(2);
            repeat (10) @(posedge clk);
            i_sdpc_req_source.send(2);
         end
         window(100);
      join
      cmp("repeater edges", 16'h0002, 16'(edges));
      wr_reg(8'h11, 16'h07F0);
      wr_reg(8'h0F, 16'h0001);
      wr_reg(8'h0F, 16'h0000);
      syncs = 0;
      lat(lat0);
      // Hold clear while the first request drains out of the longer tap
      wr_reg(8'h0F, 16'h007F);
      repeat (70) @(posedge clk);
      wr_reg(8'h0F, 16'h007E);
      lat(lat1);
      cmp("delay steps", 16'h003F, 16'(lat1 - lat0));
      cmp("sync pulses", 16'h0002, 16'(syncs));
      repeat (3) @(posedge clk);
      results();
   end
endmodule : test_sdpc_top
`default_nettype wire
